// file: verilog/serial_front_consts.vh
// Constants for the serial baud generator and receive front end.
// Function
// - Baud input is one of four prescaler taps.
// - Divide-by-16 prescaler source disables the fastest tap.
// - Integer mode divides tap by N, 1 to 16.
// - Fractional mode divides by N plus (16-K)/16.
// - Driven shift clock is baud output halved.
// - External clock gives rate /16 UART, x1 shift.
// - Timer trigger clocks UART only, at 16x rate.
// - Timer match never clocks synchronous shift mode.
// - UART clock source field picks oversample clock.
// - Source codes: timer, baud, system, external pin.
// - External shift clock edge chosen by edge select.
// - Shift mode samples line on selected clock edge.
// - Sixteen ticks per bit, vote counts 7-9.
// - Start bit needs two of three low samples.
// - Full character moves to buffer, raises interrupt, unless it overruns.
// - Only second stage readable; first keeps receiving.
// - Unread buffer plus new character flags overrun.
// - Received bit eight holds parity or ninth bit.
// - Prescaler input is selected clock divided by 4.
`ifndef SERIAL_FRONT_CONSTS_VH
`define SERIAL_FRONT_CONSTS_VH
`define OFS_BAUD_GEN_CONTROL 3'h0
`define OFS_FRACTIONAL_CONTROL 3'h1
`define OFS_SERIAL_MODE_CONTROL 3'h2
`define OFS_SERIAL_CONTROL 3'h3
`define OFS_SERIAL_BUFFER 3'h4
`define OFS_PRESCALER_CONTROL 3'h5
`define MODE_SHIFT 2'h0
`define MODE_UART7 2'h1
`define MODE_UART8 2'h2
`define MODE_UART9 2'h3
`define SRC_TIMER 2'h0
`define SRC_BAUD 2'h1
`define SRC_SYSTEM 2'h2
`define SRC_EXTERNAL 2'h3
`define PRESCALE_SRC_DIV16 2'h2
`define RST_BAUD_GEN_CONTROL 7'h04
`define RST_FRACTION_K 4'h0
`define RST_SERIAL_MODE_CONTROL 5'h00
`define RST_SERIAL_CONTROL 3'h0
`define SAMPLE_FIRST 4'h7
`define SAMPLE_LAST 4'h9
`define TICKS_LAST 4'hf
`endif

// file: verilog/serial_baud_rx_front.v
// Baud generator, clock selection and receive front end of one serial channel.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "serial_front_consts.vh"
module serial_baud_rx_front (
  input wire clock_i,
  input wire rst_n_i,
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire receive_line_i,
  input wire serial_clock_i,
  input wire timer_trigger_out_i,
  output reg serial_clock_o,
  output reg serial_clock_oe_o,
  output reg receive_interrupt_o
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_START = 4'b0010;
  localparam [3:0] ST_DATA = 4'b0100;
  localparam [3:0] ST_STOP = 4'b1000;

  // Software registers.
  reg [1:0] baud_tap_select_q;
  reg [3:0] integer_divisor_q;
  reg fractional_enable_q;
  reg [3:0] fraction_k_q;
  reg [1:0] uart_clock_source_q;
  reg [1:0] mode_q;
  reg rx_enable_q;
  reg shift_clock_direction_q;
  reg shift_edge_select_q;
  reg parity_enable_q;
  reg [1:0] prescaler_source_select_q;
  reg [7:0] serial_buffer_q;
  reg buffer_full_q;
  reg received_bit_eight_q;
  reg overrun_flag_q;

  // Pin synchronisers: bit 1 is the receive line, bit 0 the serial clock pin.
  reg [1:0] s1_q;
  reg [1:0] s2_q;
  reg [1:0] s3_q;
  reg [1:0] filt_q;
  reg [1:0] filt_prev_q;

  // Prescaler and baud generator.
  reg [3:0] src_div_q;
  reg [1:0] div4_q;
  reg [5:0] pre_q;
  reg [4:0] bcnt_q;
  reg [3:0] phase_q;
  reg baud_tick_q;
  reg sclk_q;

  // Receiver.
  reg [3:0] st_q;
  reg [3:0] cnt_q;
  reg [1:0] vote_q;
  reg [3:0] bits_q;
  reg [8:0] shr_q;

  wire acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  wire wr = acc & avs_write_i;
  wire rd = acc & avs_read_i;
  wire [2:0] widx = avs_address_i[4:2];
  wire shift_mode = (mode_q == `MODE_SHIFT);
  wire rx_line = filt_q[1];
  wire ext_rise = filt_q[0] & ~filt_prev_q[0];
  wire ext_fall = ~filt_q[0] & filt_prev_q[0];

  // The divide-by-16 source is gated here to one edge in sixteen; any other source runs the whole chain every edge.
  wire src_tick = (prescaler_source_select_q == `PRESCALE_SRC_DIV16) ?
                  (src_div_q == 4'hf) : 1'b1;
  wire t0_tick = src_tick & (div4_q == 2'h3);

  reg tap_tick;
  always @* begin
    case (baud_tap_select_q)
      2'h0: tap_tick = t0_tick & (prescaler_source_select_q != `PRESCALE_SRC_DIV16);
      2'h1: tap_tick = t0_tick & (pre_q[1:0] == 2'h3);
      2'h2: tap_tick = t0_tick & (pre_q[3:0] == 4'hf);
      default: tap_tick = t0_tick & (pre_q == 6'h3f);
    endcase
  end

  // A divisor field of zero stands for sixteen.
  wire [4:0] n_val = {integer_divisor_q == 4'h0, integer_divisor_q};
  wire frac_on = fractional_enable_q & ~shift_mode & (n_val >= 5'd2) &
                 (n_val <= 5'd15) & (fraction_k_q != 4'h0);
  wire [4:0] long_periods = 5'd16 - {1'b0, fraction_k_q};
  wire stretch = frac_on & ({1'b0, phase_q} < long_periods);
  wire [4:0] target = n_val + {4'h0, stretch};

  reg os_tick;
  always @* begin
    case (uart_clock_source_q)
      `SRC_TIMER: os_tick = timer_trigger_out_i & ~shift_mode;
      `SRC_BAUD: os_tick = baud_tick_q;
      `SRC_SYSTEM: os_tick = 1'b1;
      default: os_tick = ext_rise;
    endcase
  end

  // Shift mode edges, from the driven clock or from the pin.
  wire int_rise = baud_tick_q & ~sclk_q;
  wire int_fall = baud_tick_q & sclk_q;
  wire shift_rise = shift_clock_direction_q ? ext_rise : int_rise;
  wire shift_fall = shift_clock_direction_q ? ext_fall : int_fall;
  wire shift_edge = shift_edge_select_q ? shift_fall : shift_rise;

  // Frame length in bits between the start and stop bits.
  reg [3:0] frame_len;
  always @* begin
    case (mode_q)
      `MODE_UART7: frame_len = parity_enable_q ? 4'd8 : 4'd7;
      `MODE_UART8: frame_len = parity_enable_q ? 4'd9 : 4'd8;
      `MODE_UART9: frame_len = 4'd9;
      default: frame_len = 4'd8;
    endcase
  end

  wire [1:0] ones = vote_q + {1'b0, rx_line};
  wire maj = ones[1];
  wire uart_bit = ~shift_mode & os_tick & (cnt_q == `SAMPLE_LAST) & st_q[2];
  wire shift_bit = shift_mode & shift_edge;
  wire take_bit = uart_bit | shift_bit;
  wire new_bit = shift_mode ? rx_line : maj;
  wire [8:0] shr_next = {new_bit, shr_q[8:1]};
  wire [3:0] bits_next = bits_q + 4'h1;
  wire done = rx_enable_q & take_bit & (bits_next == frame_len);
  wire [8:0] aligned = shr_next >> (4'd9 - frame_len);

  reg [31:0] rdata;
  always @* begin
    case (widx)
      `OFS_BAUD_GEN_CONTROL:
        rdata = {25'h0, fractional_enable_q, integer_divisor_q, baud_tap_select_q};
      `OFS_FRACTIONAL_CONTROL: rdata = {28'h0, fraction_k_q};
      `OFS_SERIAL_MODE_CONTROL:
        rdata = {27'h0, rx_enable_q, mode_q, uart_clock_source_q};
      `OFS_SERIAL_CONTROL:
        rdata = {26'h0, buffer_full_q, received_bit_eight_q, overrun_flag_q,
                 parity_enable_q, shift_edge_select_q, shift_clock_direction_q};
      `OFS_SERIAL_BUFFER: rdata = {24'h0, serial_buffer_q};
      `OFS_PRESCALER_CONTROL: rdata = {30'h0, prescaler_source_select_q};
      default: rdata = 32'h0;
    endcase
  end

  // Bus slave: one wait cycle, then the access completes.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o) begin
        avs_readdata_o <= rdata;
      end
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      {fractional_enable_q, integer_divisor_q, baud_tap_select_q} <= `RST_BAUD_GEN_CONTROL;
      fraction_k_q <= `RST_FRACTION_K;
      {rx_enable_q, mode_q, uart_clock_source_q} <= `RST_SERIAL_MODE_CONTROL;
      {parity_enable_q, shift_edge_select_q, shift_clock_direction_q} <= `RST_SERIAL_CONTROL;
      prescaler_source_select_q <= 2'h0;
    end else if (wr) begin
      case (widx)
        `OFS_BAUD_GEN_CONTROL: begin
          baud_tap_select_q <= avs_writedata_i[1:0];
          integer_divisor_q <= avs_writedata_i[5:2];
          fractional_enable_q <= avs_writedata_i[6];
        end
        `OFS_FRACTIONAL_CONTROL: fraction_k_q <= avs_writedata_i[3:0];
        `OFS_SERIAL_MODE_CONTROL: begin
          uart_clock_source_q <= avs_writedata_i[1:0];
          mode_q <= avs_writedata_i[3:2];
          rx_enable_q <= avs_writedata_i[4];
        end
        `OFS_SERIAL_CONTROL: begin
          shift_clock_direction_q <= avs_writedata_i[0];
          shift_edge_select_q <= avs_writedata_i[1];
          parity_enable_q <= avs_writedata_i[2];
        end
        `OFS_PRESCALER_CONTROL: prescaler_source_select_q <= avs_writedata_i[1:0];
        default: begin
        end
      endcase
    end
  end

  // A change on a pin counts only once the second and third stages agree.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
      filt_q <= 2'h3;
      filt_prev_q <= 2'h3;
    end else begin
      s1_q <= {receive_line_i, serial_clock_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q ~^ s3_q) & s3_q | ~(s2_q ~^ s3_q) & filt_q;
      filt_prev_q <= filt_q;
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      src_div_q <= 4'h0;
      div4_q <= 2'h0;
      pre_q <= 6'h0;
      bcnt_q <= 5'h0;
      phase_q <= 4'h0;
      baud_tick_q <= 1'b0;
    end else begin
      src_div_q <= src_div_q + 4'h1;
      if (src_tick) begin
        div4_q <= div4_q + 2'h1;
      end
      if (t0_tick) begin
        pre_q <= pre_q + 6'h1;
      end
      baud_tick_q <= 1'b0;
      if (tap_tick) begin
        if (bcnt_q + 5'h1 >= target) begin
          bcnt_q <= 5'h0;
          baud_tick_q <= 1'b1;
          phase_q <= phase_q + 4'h1;
        end else begin
          bcnt_q <= bcnt_q + 5'h1;
        end
      end
    end
  end

  // The driven shift clock idles high and toggles on each baud tick.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b1;
      serial_clock_o <= 1'b1;
      serial_clock_oe_o <= 1'b0;
    end else begin
      if (shift_mode & ~shift_clock_direction_q & rx_enable_q) begin
        if (baud_tick_q) begin
          sclk_q <= ~sclk_q;
        end
      end else begin
        sclk_q <= 1'b1;
      end
      serial_clock_o <= sclk_q;
      serial_clock_oe_o <= shift_mode & ~shift_clock_direction_q;
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i || !rx_enable_q) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      vote_q <= 2'h0;
      bits_q <= 4'h0;
      shr_q <= 9'h0;
    end else if (shift_mode) begin
      if (shift_bit) begin
        shr_q <= shr_next;
        bits_q <= done ? 4'h0 : bits_next;
      end
    end else if (os_tick) begin
      case (st_q)
        ST_IDLE: begin
          cnt_q <= 4'h0;
          vote_q <= 2'h0;
          bits_q <= 4'h0;
          if (!rx_line) begin
            st_q <= ST_START;
          end
        end
        ST_START, ST_DATA, ST_STOP: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q >= `SAMPLE_FIRST && cnt_q < `SAMPLE_LAST) begin
            vote_q <= ones;
          end
          if (cnt_q == `TICKS_LAST) begin
            vote_q <= 2'h0;
            if (st_q == ST_START) begin
              st_q <= ST_DATA;
            end
          end
          if (cnt_q == `SAMPLE_LAST) begin
            if (st_q == ST_START && maj) begin
              st_q <= ST_IDLE;
            end else if (st_q == ST_DATA) begin
              shr_q <= shr_next;
              bits_q <= bits_next;
              if (done) begin
                st_q <= ST_STOP;
              end
            end else if (st_q == ST_STOP) begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Second stage and flags; a new event wins over a clear in the same cycle.
  wire buf_read = rd & (widx == `OFS_SERIAL_BUFFER);
  wire ovr_clear = wr & (widx == `OFS_SERIAL_CONTROL) & avs_writedata_i[3];
  wire overrun = done & buffer_full_q & ~buf_read;
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      serial_buffer_q <= 8'h0;
      received_bit_eight_q <= 1'b0;
      buffer_full_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      receive_interrupt_o <= 1'b0;
    end else begin
      receive_interrupt_o <= done & ~overrun;
      if (overrun) begin
        overrun_flag_q <= 1'b1;
      end else if (ovr_clear) begin
        overrun_flag_q <= 1'b0;
      end
      if (done & ~overrun) begin
        serial_buffer_q <= aligned[7:0];
        received_bit_eight_q <= aligned[8];
        buffer_full_q <= 1'b1;
      end else if (buf_read) begin
        buffer_full_q <= 1'b0;
      end
    end
  end
endmodule // serial_baud_rx_front

// file: tb/serial_front_asserts.sv
// Port checks for the serial baud and receive front end.
`timescale 1ns/1ps
module serial_front_asserts (
  input wire clock_i,
  input wire rst_n_i,
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire serial_clock_o,
  input wire serial_clock_oe_o,
  input wire receive_interrupt_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("access not answered after one wait");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!avs_read_i && !avs_write_i |-> avs_waitrequest_o)
    else $error("waitrequest low while idle");
  a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o
    |-> avs_readdata_o[31:8] == 24'h000000) else $error("upper read bits set");
  a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o &&
    avs_address_i[4:3] == 2'h3 |=> avs_readdata_o == 32'h0) else $error("unmapped read");
  a_irq_pulse: assert property (receive_interrupt_o |=> !receive_interrupt_o)
    else $error("interrupt wider than one cycle");
  a_irq_spacing: assert property ($rose(receive_interrupt_o) |=>
    (!receive_interrupt_o) [*8]) else $error("interrupts too close");
  a_shift_half: assert property (serial_clock_oe_o && $changed(serial_clock_o) |=>
    (!serial_clock_oe_o || $stable(serial_clock_o)) [*3]) else $error("shift clock fast");
endmodule // serial_front_asserts
bind serial_baud_rx_front serial_front_asserts serial_front_asserts_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .serial_clock_o(serial_clock_o),
  .serial_clock_oe_o(serial_clock_oe_o), .receive_interrupt_o(receive_interrupt_o));

// file: tb/line_peer.sv
// Remote serial transmitter driving the receive line.
`timescale 1ns/1ps
module line_peer (
  input wire clock_i,
  output logic receive_line_o,
  output logic serial_clock_o
);
  initial begin
    receive_line_o = 1'b1;
    serial_clock_o = 1'b1;
  end
  task send(input logic [8:0] d, input int n, input int bitc);
    int i;
    for (i = -1; i <= n; i++) begin
      @(posedge clock_i);
      receive_line_o <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
      repeat (bitc - 1) @(posedge clock_i);
    end
  endtask
  task pulse(input int w);
    @(posedge clock_i);
    receive_line_o <= 1'b0;
    repeat (w) @(posedge clock_i);
    receive_line_o <= 1'b1;
  endtask
  // Data is valid only around the selected edge, so a wrong edge choice reads the inverse.
  task shift_in(input logic [7:0] d, input logic fall);
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge clock_i);
      receive_line_o <= d[i] ^ !fall;
      repeat (4) @(posedge clock_i);
      serial_clock_o <= 1'b0;
      repeat (4) @(posedge clock_i);
      receive_line_o <= d[i] ^ fall;
      repeat (4) @(posedge clock_i);
      serial_clock_o <= 1'b1;
      repeat (4) @(posedge clock_i);
    end
    receive_line_o <= 1'b1;
  endtask
endmodule // line_peer

// file: tb/test_serial_baud_rx_front.sv
// Self-checking bench for the serial baud and receive front end.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_serial_baud_rx_front;
  logic clock_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, tmr = 1'b0, ext = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic rxl, sco, soe, irq, wt;
  logic pclk, peer_clk_on = 1'b0;
  logic [7:0] fcnt = 8'h00;
  int err_total = 0, samples_checked = 0, irq_cnt = 0, cyc = 0, c;
  initial forever #10 clock_i = ~clock_i;
  serial_baud_rx_front serial_baud_rx_front_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .receive_line_i(rxl),
    .serial_clock_i(peer_clk_on ? pclk : ext), .timer_trigger_out_i(tmr),
    .serial_clock_o(sco), .serial_clock_oe_o(soe), .receive_interrupt_o(irq));
  line_peer line_peer_i (.clock_i(clock_i), .receive_line_o(rxl), .serial_clock_o(pclk));
  always @(posedge clock_i) begin
    fcnt <= fcnt + 8'h01;
    tmr <= (fcnt[2:0] == 3'h7);
    ext <= fcnt[3];
    if (irq === 1'b1) irq_cnt++;
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      complete_run;
    end
  end
  task complete_run;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clock_i); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q & m, e)
  endtask
  task uart_case(input logic [1:0] s, input logic [6:0] w0, input logic [3:0] k,
                 input int bitc, input logic [8:0] d, input logic nine);
    bus(1'b1, 5'h00, {25'h0, w0});
    bus(1'b1, 5'h04, {28'h0, k});
    bus(1'b1, 5'h08, {27'h0, 2'h3, nine, s});
    c = irq_cnt;
    line_peer_i.send(d, nine ? 9 : 8, bitc);
    `CHK(irq_cnt - c, 1)
    chk(5'h10, 32'hff, {24'h0, d[7:0]});
    chk(5'h0c, nine ? 32'h30 : 32'h20, {27'h0, d[8] & nine, 4'h0});
  endtask
  task shift_rate(input logic [1:0] ps, input logic [6:0] w0, input int lo, input int hi);
    int t;
    logic s;
    bus(1'b1, 5'h14, {30'h0, ps});
    bus(1'b1, 5'h00, {25'h0, w0});
    bus(1'b1, 5'h08, 32'h10);
    t = 0;
    s = sco;
    repeat (64) begin
      @(posedge clock_i);
      if (sco !== s) t++;
      s = sco;
    end
    `CHK(soe, 1'b1)
    `CHK(t >= lo && t <= hi, 1'b1)
  endtask
  task shift_rx_case(input logic fall, input logic [7:0] d);
    bus(1'b1, 5'h08, 32'h00);
    peer_clk_on <= 1'b1;
    bus(1'b1, 5'h0c, {30'h0, fall, 1'b1});
    bus(1'b0, 5'h10, 32'h0);
    bus(1'b1, 5'h08, 32'h10);
    c = irq_cnt;
    line_peer_i.shift_in(d, fall);
    repeat (8) @(posedge clock_i);
    `CHK(irq_cnt - c, 1)
    chk(5'h10, 32'hff, {24'h0, d});
    bus(1'b1, 5'h08, 32'h00);
    peer_clk_on <= 1'b0;
  endtask
  task uart_mode_case(input logic [1:0] md, input logic par, input int n,
                      input logic [8:0] d);
    bus(1'b1, 5'h0c, {29'h0, par, 2'h0});
    bus(1'b1, 5'h08, {27'h0, 1'b1, md, 2'h2});
    c = irq_cnt;
    line_peer_i.send(d, n, 16);
    `CHK(irq_cnt - c, 1)
    chk(5'h10, 32'hff, {24'h0, d[7:0]});
    chk(5'h0c, 32'h10, {27'h0, d[8], 4'h0});
  endtask
  task glitch_case;
    c = irq_cnt;
    line_peer_i.pulse(4);
    repeat (300) @(posedge clock_i);
    `CHK(irq_cnt - c, 0)
  endtask
  task overrun_case;
    bus(1'b1, 5'h0c, 32'h08);
    chk(5'h0c, 32'h08, 32'h0);
    bus(1'b1, 5'h08, 32'h1a);
    c = irq_cnt;
    line_peer_i.send(9'h03c, 8, 16);
    line_peer_i.send(9'h0c3, 8, 16);
    `CHK(irq_cnt - c, 1)
    chk(5'h0c, 32'h28, 32'h28);
    chk(5'h10, 32'hff, 32'h3c);
    bus(1'b1, 5'h0c, 32'h08);
    chk(5'h0c, 32'h28, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) chk({i[2:0], 2'h0}, 32'hffffffff, i == 0 ? 32'h4 : 32'h0);
    shift_rate(2'h0, 7'h04, 15, 17);
    shift_rate(2'h2, 7'h04, 0, 0);
    shift_rate(2'h0, 7'h05, 3, 5);
    shift_rate(2'h0, 7'h08, 7, 9);
    shift_rate(2'h0, 7'h00, 0, 2);
    bus(1'b1, 5'h0c, 32'h1);
    repeat (2) @(posedge clock_i);
    `CHK(soe, 1'b0)
    shift_rx_case(1'b0, 8'h96);
    shift_rx_case(1'b1, 8'h4b);
    bus(1'b1, 5'h0c, 32'h0);
    bus(1'b1, 5'h14, 32'h0);
    uart_case(2'h2, 7'h04, 4'h0, 16, 9'h0a5, 1'b0);
    uart_case(2'h1, 7'h04, 4'hf, 64, 9'h05a, 1'b0);
    uart_case(2'h1, 7'h48, 4'h8, 160, 9'h0c3, 1'b0);
    uart_case(2'h0, 7'h04, 4'h0, 128, 9'h03c, 1'b0);
    uart_case(2'h3, 7'h04, 4'h0, 256, 9'h096, 1'b0);
    uart_case(2'h2, 7'h04, 4'h0, 16, 9'h15a, 1'b1);
    uart_mode_case(2'h1, 1'b0, 7, 9'h055);
    uart_mode_case(2'h1, 1'b1, 8, 9'h0d5);
    uart_mode_case(2'h2, 1'b1, 9, 9'h1a5);
    glitch_case;
    overrun_case;
    complete_run;
  end
endmodule // test_serial_baud_rx_front
